// ==== common/ocg_params.svh ====
`ifndef OCG_PARAMS_SVH
`define OCG_PARAMS_SVH

// channel count and decode
`define OCG_NUM_CH 8
`define OCG_CODE_W 3
`define OCG_GLOBAL_BIT 7
`define OCG_CH_SEL_HI 6
`define OCG_CH_SEL_LO 4
`define OCG_CH_OFF_HI 3

// global register addresses
`define OCG_ADDR_SUMMARY 8'h80
`define OCG_ADDR_SRC_LOW 8'h81
`define OCG_ADDR_SRC_MID 8'h82
`define OCG_ADDR_SRC_HIGH 8'h83
`define OCG_ADDR_TCTRL 8'h84
`define OCG_ADDR_TSTAT 8'h85
`define OCG_ADDR_TVAL_LO 8'h86
`define OCG_ADDR_TVAL_HI 8'h87
`define OCG_ADDR_OCTO 8'h88
`define OCG_ADDR_QUAD 8'h89
`define OCG_ADDR_SRST 8'h8A
`define OCG_ADDR_SLEEP 8'h8B
`define OCG_ADDR_REV 8'h8C
`define OCG_ADDR_ID 8'h8D
`define OCG_ADDR_BCAST 8'h8E

// channel register offsets that clear the summary bit
`define OCG_OFF_STATUS 4'h2
`define OCG_OFF_LINE 4'h5
`define OCG_OFF_MODEM 4'h6

// fields
`define OCG_TCTRL_W 4
`define OCG_TCTRL_IRQ_EN 0
`define OCG_TSTAT_TIMEOUT 0
`define OCG_BCAST_EN 0
`define OCG_CODE_NONE 3'h0
`define OCG_CODE_TIMER 3'h7
`define OCG_BYTE_ZERO 8'h00
`define OCG_BYTE_ONES 8'hFF

// pin bundle layout: addr, data, cs_n, rd_n, wr_n
`define OCG_PINS_W 19
`define OCG_PIN_ADDR_LO 11
`define OCG_PIN_DATA_LO 3
`define OCG_PIN_CS 2
`define OCG_PIN_RD 1
`define OCG_PIN_WR 0
`define OCG_PINS_IDLE 19'h7FFFF

// identity defaults, values arbitrary
`define OCG_REV_DEFAULT 8'h01
`define OCG_ID_DEFAULT 8'h5A

`endif

// ==== common/ocg_pkg.sv ====
package ocg_pkg;

	typedef enum logic [1:0] {
		OCG_IDLE = 2'b01,
		OCG_CHAN_RD = 2'b10
	} ocg_bus_e;

	typedef logic [7:0] ocg_byte_t;

endpackage : ocg_pkg

// ==== rtl/ocg_pin_sync.sv ====
`timescale 1ns/1ps
`include "ocg_params.svh"

module ocg_pin_sync
	import ocg_pkg::*;
#(
	parameter int WIDTH = `OCG_PINS_W,
	parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out,
	output logic [WIDTH-1:0] fall_out
);

	if (WIDTH < 1) begin : g_bad_width
		$error("ocg_pin_sync: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] s1_q, s2_q, s3_q, level_q, fall_q;
	logic [WIDTH-1:0] level_d, fall_d;

	// a bit moves only once stages two and three agree
	always_comb begin
		level_d = (level_q & ~(s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));
		level_d = ((s2_q ~^ s3_q) & s2_q) | (~(s2_q ~^ s3_q) & level_q);
		fall_d = level_q & ~level_d;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_q <= IDLE_LEVEL;
			s2_q <= IDLE_LEVEL;
			s3_q <= IDLE_LEVEL;
			level_q <= IDLE_LEVEL;
			fall_q <= '0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
			fall_q <= fall_d;
		end
	end

	assign level_out = level_q;
	assign fall_out = fall_q;

endmodule : ocg_pin_sync

// ==== rtl/ocg_global_regs.sv ====
`timescale 1ns/1ps
`include "ocg_params.svh"

// Behaviour
// R1: eight sixteen-address channel blocks below 0x80
// R2: global registers at 0x80-0x8F, no paging
// R3: channel offsets forwarded unchanged to channels
// R4: summary register bit n flags channel n
// R5: 3-bit codes packed over three registers
// R6: all four interrupt registers reset zero
// R7: only CHANNEL_IRQ_ENABLE-enabled channel interrupts reported
// R8: timer interrupt masked locally by TCTRL bit 0; wake interrupt has no mask
// R9: wake interrupt only after all channels slept
// R10: timer control, status and value registers
// R11: per-channel 8x and 4x select registers
// R12: sleep enable register at 0x8B
// R13: write-only soft reset register at 0x8A
// R14: broadcast bit makes writes hit all channels
// R15: read-only revision and identity registers
// R16: host uses plain reads and writes
// R17: status reads clear channel summary bit
// R18: code seven only as channel-0 timer; a channel-0 source code of seven is still reported unchanged
// R19: 8x select wins over 4x
// R20: broadcast writes all channels, reads addressed
module ocg_global_regs
	import ocg_pkg::*;
#(
	parameter ocg_byte_t REVISION = `OCG_REV_DEFAULT,
	parameter ocg_byte_t IDENTITY = `OCG_ID_DEFAULT,
	parameter int NUM_CH = `OCG_NUM_CH
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] bus_addr_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic bus_cs_n_in,
	input wire logic bus_rd_n_in,
	input wire logic bus_wr_n_in,
	output logic [7:0] bus_rdata_out,
	output logic bus_rdata_oe_n_out,
	input wire logic [23:0] chan_src_code_in,
	input wire logic [7:0] chan_irq_enabled_in,
	input wire logic [63:0] chan_rdata_in,
	input wire logic timer_timeout_in,
	input wire logic device_asleep_in,
	output logic [3:0] chan_offset_out,
	output logic [7:0] chan_wdata_out,
	output logic [7:0] chan_wr_out,
	output logic [7:0] chan_rd_out,
	output logic [7:0] chan_soft_reset_out,
	output logic [7:0] octo_mode_out,
	output logic [7:0] quad_mode_out,
	output logic [7:0] sleep_enable_out,
	output logic [3:0] timer_control_out,
	output logic [15:0] timer_value_out
);

	if (NUM_CH != `OCG_NUM_CH) begin : g_bad_ch
		$error("ocg_global_regs: only eight channels are supported");
	end

	function automatic logic [7:0] ocg_onehot(input logic [2:0] idx);
		return 8'h01 << idx;
	endfunction : ocg_onehot

	// masked, reserved-filtered source code of one channel
	function automatic logic [2:0] ocg_eff_code(input int ch, input logic [2:0] code,
			input logic en);
		if (!en)
			return `OCG_CODE_NONE;
		if (ch != 0 && code == `OCG_CODE_TIMER)
			return `OCG_CODE_NONE;
		return code;
	endfunction : ocg_eff_code

	////////////////////////////////////////////////////////////////////////
	// pin capture

	logic [`OCG_PINS_W-1:0] pins_raw, pins_lvl, pins_fall;
	logic [7:0] addr_s, wdata_s;
	logic cs_low, rd_ev, wr_ev, is_global;
	logic [2:0] ch_sel;
	logic [3:0] ch_off;

	assign pins_raw = {bus_addr_in, bus_wdata_in, bus_cs_n_in, bus_rd_n_in, bus_wr_n_in};

	ocg_pin_sync #(
		.WIDTH(`OCG_PINS_W),
		.IDLE_LEVEL(`OCG_PINS_IDLE)
	) u_pin_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.pin_in(pins_raw),
		.level_out(pins_lvl),
		.fall_out(pins_fall)
	);

	assign addr_s = pins_lvl[`OCG_PIN_ADDR_LO +: 8];
	assign wdata_s = pins_lvl[`OCG_PIN_DATA_LO +: 8];
	assign cs_low = !pins_lvl[`OCG_PIN_CS];
	assign rd_ev = pins_fall[`OCG_PIN_RD] && cs_low;
	assign wr_ev = pins_fall[`OCG_PIN_WR] && cs_low;
	assign is_global = addr_s[`OCG_GLOBAL_BIT]; // R2
	assign ch_sel = addr_s[`OCG_CH_SEL_HI:`OCG_CH_SEL_LO]; // R1
	assign ch_off = addr_s[`OCG_CH_OFF_HI:0];

	////////////////////////////////////////////////////////////////////////
	// bus and configuration registers

	ocg_bus_e state_q, state_d;
	ocg_byte_t rdata_q, rdata_d, cwdata_q, cwdata_d;
	logic oe_n_q, oe_n_d;
	logic [3:0] offset_q, offset_d, tctrl_q, tctrl_d;
	logic [2:0] rd_sel_q, rd_sel_d;
	logic [7:0] chan_wr_q, chan_wr_d, chan_rd_q, chan_rd_d, srst_q, srst_d;
	logic [7:0] octo_q, octo_d, quad_q, quad_d, quad_eff_q, quad_eff_d, sleep_q, sleep_d;
	logic [15:0] tval_q, tval_d;
	logic bcast_q, bcast_d;
	logic [23:0] code_q;
	logic [7:0] summary_q;
	logic tflag_q;

	always_comb begin
		state_d = state_q;
		rdata_d = rdata_q;
		oe_n_d = !(cs_low && !pins_lvl[`OCG_PIN_RD]);
		offset_d = offset_q;
		cwdata_d = cwdata_q;
		rd_sel_d = rd_sel_q;
		chan_wr_d = `OCG_BYTE_ZERO;
		chan_rd_d = `OCG_BYTE_ZERO;
		srst_d = `OCG_BYTE_ZERO;
		tctrl_d = tctrl_q;
		tval_d = tval_q;
		octo_d = octo_q;
		quad_d = quad_q;
		sleep_d = sleep_q;
		bcast_d = bcast_q;
		if (wr_ev) begin
			if (!is_global) begin
				offset_d = ch_off; // R3
				cwdata_d = wdata_s;
				chan_wr_d = bcast_q ? `OCG_BYTE_ONES : ocg_onehot(ch_sel); // R1 R14 R20
			end else begin
				case (addr_s) // R16
					`OCG_ADDR_TCTRL: tctrl_d = wdata_s[`OCG_TCTRL_W-1:0]; // R10
					`OCG_ADDR_TVAL_LO: tval_d[7:0] = wdata_s; // R10
					`OCG_ADDR_TVAL_HI: tval_d[15:8] = wdata_s; // R10
					`OCG_ADDR_OCTO: octo_d = wdata_s; // R11
					`OCG_ADDR_QUAD: quad_d = wdata_s; // R11
					`OCG_ADDR_SRST: srst_d = wdata_s; // R13
					`OCG_ADDR_SLEEP: sleep_d = wdata_s; // R12
					`OCG_ADDR_BCAST: bcast_d = wdata_s[`OCG_BCAST_EN]; // R14
					default: bcast_d = bcast_q;
				endcase
			end
		end
		quad_eff_d = quad_d & ~octo_d; // R19
		case (state_q)
			OCG_IDLE: begin
				if (rd_ev && !is_global) begin
					offset_d = ch_off; // R3
					rd_sel_d = ch_sel;
					chan_rd_d = ocg_onehot(ch_sel); // R20
					state_d = OCG_CHAN_RD;
				end else if (rd_ev) begin
					case (addr_s)
						`OCG_ADDR_SUMMARY: rdata_d = summary_q; // R4
						`OCG_ADDR_SRC_LOW: rdata_d = code_q[7:0]; // R5
						`OCG_ADDR_SRC_MID: rdata_d = code_q[15:8]; // R5
						`OCG_ADDR_SRC_HIGH: rdata_d = code_q[23:16]; // R5
						`OCG_ADDR_TCTRL: rdata_d = {4'h0, tctrl_q}; // R10
						`OCG_ADDR_TSTAT: rdata_d = {7'h00, tflag_q}; // R10
						`OCG_ADDR_TVAL_LO: rdata_d = tval_q[7:0];
						`OCG_ADDR_TVAL_HI: rdata_d = tval_q[15:8];
						`OCG_ADDR_OCTO: rdata_d = octo_q;
						`OCG_ADDR_QUAD: rdata_d = quad_q;
						`OCG_ADDR_SLEEP: rdata_d = sleep_q;
						`OCG_ADDR_REV: rdata_d = REVISION; // R15
						`OCG_ADDR_ID: rdata_d = IDENTITY; // R15
						`OCG_ADDR_BCAST: rdata_d = {7'h00, bcast_q}; // R14
						default: rdata_d = `OCG_BYTE_ZERO;
					endcase
				end
			end
			OCG_CHAN_RD: begin
				rdata_d = chan_rdata_in[rd_sel_q*8 +: 8]; // R20
				state_d = OCG_IDLE;
			end
			default: state_d = OCG_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= OCG_IDLE;
			rdata_q <= `OCG_BYTE_ZERO;
			oe_n_q <= 1'b1;
			offset_q <= 4'h0;
			cwdata_q <= `OCG_BYTE_ZERO;
			rd_sel_q <= 3'h0;
			chan_wr_q <= `OCG_BYTE_ZERO;
			chan_rd_q <= `OCG_BYTE_ZERO;
			srst_q <= `OCG_BYTE_ZERO;
			tctrl_q <= 4'h0;
			tval_q <= 16'h0000;
			octo_q <= `OCG_BYTE_ZERO;
			quad_q <= `OCG_BYTE_ZERO;
			quad_eff_q <= `OCG_BYTE_ZERO;
			sleep_q <= `OCG_BYTE_ZERO;
			bcast_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rdata_q <= rdata_d;
			oe_n_q <= oe_n_d;
			offset_q <= offset_d;
			cwdata_q <= cwdata_d;
			rd_sel_q <= rd_sel_d;
			chan_wr_q <= chan_wr_d;
			chan_rd_q <= chan_rd_d;
			srst_q <= srst_d;
			tctrl_q <= tctrl_d;
			tval_q <= tval_d;
			octo_q <= octo_d;
			quad_q <= quad_d;
			quad_eff_q <= quad_eff_d;
			sleep_q <= sleep_d;
			bcast_q <= bcast_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt summary, source codes, timer flag, wake-up

	logic [23:0] code_d;
	logic [7:0] summary_d, sum_set, sum_clr;
	logic tflag_d, tstat_clr, wake_q, wake_d, armed_q, armed_d, asleep_q, wake_set;

	assign tstat_clr = rd_ev && state_q == OCG_IDLE && addr_s == `OCG_ADDR_TSTAT;
	assign wake_set = asleep_q && !device_asleep_in && armed_q; // R9

	always_comb begin
		sum_clr = `OCG_BYTE_ZERO;
		if (rd_ev && state_q == OCG_IDLE && !is_global && (ch_off == `OCG_OFF_STATUS
				|| ch_off == `OCG_OFF_LINE || ch_off == `OCG_OFF_MODEM))
			sum_clr = ocg_onehot(ch_sel); // R17
		for (int n = 0; n < `OCG_NUM_CH; n++) begin
			code_d[n*3 +: 3] = ocg_eff_code(n, chan_src_code_in[n*3 +: 3],
				chan_irq_enabled_in[n]); // R7 R18
		end
		if (code_d[2:0] == `OCG_CODE_NONE && tflag_q && tctrl_q[`OCG_TCTRL_IRQ_EN])
			code_d[2:0] = `OCG_CODE_TIMER; // R8 R18
		for (int n = 0; n < `OCG_NUM_CH; n++) begin
			sum_set[n] = code_d[n*3 +: 3] != `OCG_CODE_NONE;
		end
		// wake flag and its summary bit clear together on the status read
		wake_d = (wake_q && !sum_clr[0]) || wake_set; // R8 R9
		sum_set[0] = sum_set[0] || wake_d;
		summary_d = (summary_q & ~sum_clr) | sum_set; // R4 R17
		tflag_d = (tflag_q && !tstat_clr) || timer_timeout_in;
		armed_d = (armed_q || (device_asleep_in && sleep_q == `OCG_BYTE_ONES)) && !wake_set;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			code_q <= 24'h000000; // R6
			summary_q <= `OCG_BYTE_ZERO; // R6
			tflag_q <= 1'b0;
			armed_q <= 1'b0;
			wake_q <= 1'b0;
			asleep_q <= 1'b0;
		end else begin
			code_q <= code_d;
			summary_q <= summary_d;
			tflag_q <= tflag_d;
			armed_q <= armed_d;
			wake_q <= wake_d;
			asleep_q <= device_asleep_in;
		end
	end

	assign bus_rdata_out = rdata_q;
	assign bus_rdata_oe_n_out = oe_n_q;
	assign chan_offset_out = offset_q;
	assign chan_wdata_out = cwdata_q;
	assign chan_wr_out = chan_wr_q;
	assign chan_rd_out = chan_rd_q;
	assign chan_soft_reset_out = srst_q;
	assign octo_mode_out = octo_q;
	assign quad_mode_out = quad_eff_q;
	assign sleep_enable_out = sleep_q;
	assign timer_control_out = tctrl_q;
	assign timer_value_out = tval_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_glob_wr(logic [7:0] a);
		wr_ev && addr_s == a;
	endsequence

	sequence s_glob_rd(logic [7:0] a);
		rd_ev && state_q == OCG_IDLE && addr_s == a;
	endsequence

	chk_reset_zero: assert property ($fell(rst_in) |-> summary_q == 8'h00 && code_q == 24'h0) // R6
		else $error("interrupt registers not zero after reset");
	chk_chan_decode: assert property (wr_ev && !is_global && !bcast_q |=> // R1
		chan_wr_out == ocg_onehot($past(ch_sel)) && chan_offset_out == $past(ch_off))
		else $error("channel write strobe decoded wrong");
	chk_global_no_chan: assert property (wr_ev && is_global |=> chan_wr_out == 8'h00) // R2
		else $error("global write reached a channel");
	chk_bcast_write: assert property (wr_ev && !is_global && bcast_q |=> chan_wr_out == 8'hFF) // R20
		else $error("broadcast write missed channels");
	chk_summary_read: assert property (s_glob_rd(`OCG_ADDR_SUMMARY) |=> // R4
		bus_rdata_out == $past(summary_q))
		else $error("summary read data wrong");
	chk_source_read: assert property (s_glob_rd(`OCG_ADDR_SRC_MID) |=> // R5
		bus_rdata_out == $past(code_q[15:8]))
		else $error("source code read data wrong");
	chk_timer_ctrl: assert property (s_glob_rd(`OCG_ADDR_TCTRL) |=> bus_rdata_out[7:4] == 4'h0) // R10
		else $error("timer control upper bits not zero");
	chk_code_masked: assert property (!chan_irq_enabled_in[6] |=> code_q[20:18] == 3'h0) // R7
		else $error("disabled channel interrupt reported");
	chk_code_reserved: assert property (code_q[5:3] != 3'h7 && code_q[8:6] != 3'h7 // R18
		&& code_q[11:9] != 3'h7 && code_q[14:12] != 3'h7 && code_q[17:15] != 3'h7
		&& code_q[20:18] != 3'h7 && code_q[23:21] != 3'h7)
		else $error("reserved code seven on channel above zero");
	chk_timer_gate: assert property (!tctrl_q[0] && chan_src_code_in[2:0] == 3'h0 // R8
		&& chan_irq_enabled_in[0] |=> code_q[2:0] == 3'h0)
		else $error("masked timer interrupt reported");
	chk_quad_prec: assert property ((quad_mode_out & octo_mode_out) == 8'h00) // R19
		else $error("4x select active with 8x select");
	chk_quad_write: assert property (s_glob_wr(`OCG_ADDR_QUAD) |=> // R19
		quad_mode_out == ($past(wdata_s) & ~octo_mode_out))
		else $error("4x select write not applied");
	chk_soft_reset: assert property (s_glob_wr(`OCG_ADDR_SRST) |=> // R13
		chan_soft_reset_out == $past(wdata_s) ##1 chan_soft_reset_out == 8'h00)
		else $error("soft reset pulse wrong");
	chk_sleep_write: assert property (s_glob_wr(`OCG_ADDR_SLEEP) |=> // R12
		sleep_enable_out == $past(wdata_s))
		else $error("sleep register not written");
	chk_wake_irq: assert property (wake_set |=> summary_q[0] ##0 wake_q) // R9
		else $error("wake-up interrupt not raised");
	chk_status_clear: assert property (sum_clr[3] && code_d[11:9] == 3'h0 |=> !summary_q[3]) // R17
		else $error("summary bit not cleared by status read");

endmodule : ocg_global_regs

// ==== testbench/ocg_host_model.sv ====
`timescale 1ns/1ps

module ocg_host_model
	import ocg_pkg::*;
(
	input wire logic clk_in,
	output logic [7:0] bus_addr_out,
	output logic [7:0] bus_wdata_out,
	output logic bus_cs_n_out,
	output logic bus_rd_n_out,
	output logic bus_wr_n_out,
	input wire logic [7:0] bus_rdata_in,
	input wire logic bus_rdata_oe_n_in
);
	initial begin
		bus_addr_out = 8'h00;
		bus_wdata_out = 8'h00;
		bus_cs_n_out = 1'b1;
		bus_rd_n_out = 1'b1;
		bus_wr_n_out = 1'b1;
	end
	////////////////////////////////////////
	// one plain bus cycle, pins held across the strobe
	task automatic access(input ocg_byte_t addr, input ocg_byte_t data, input logic is_rd,
		output ocg_byte_t rdata, output logic oe_on, output logic oe_off);
		@(posedge clk_in);
		bus_addr_out <= addr;
		bus_wdata_out <= data;
		bus_cs_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		if (is_rd) begin
			bus_rd_n_out <= 1'b0;
		end else begin
			bus_wr_n_out <= 1'b0;
		end
		repeat (8) @(posedge clk_in);
		#1;
		rdata = bus_rdata_in;
		oe_on = bus_rdata_oe_n_in;
		@(posedge clk_in);
		bus_rd_n_out <= 1'b1;
		bus_wr_n_out <= 1'b1;
		bus_cs_n_out <= 1'b1;
		bus_wdata_out <= ~data;
		bus_addr_out <= ~addr;
		repeat (6) @(posedge clk_in);
		#1;
		oe_off = bus_rdata_oe_n_in;
	endtask : access
endmodule : ocg_host_model

// ==== testbench/ocg_global_regs_bench.sv ====
`timescale 1ns/1ps

module ocg_global_regs_bench
	import ocg_pkg::*;
;
	localparam ocg_byte_t REV_VAL = 8'hA5; // arbitrary value
	localparam ocg_byte_t ID_VAL = 8'h3C; // arbitrary value
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr, wdata, rdata, last_wr, last_rd, last_rst, last_wd;
	logic cs_n, rd_n, wr_n, oe_n, timeout, asleep;
	logic [3:0] last_off, tctrl;
	logic [23:0] src, exp_src;
	logic [7:0] irq_en, c_wr, c_rd, c_rst, c_wd, octo, quad, sleep;
	logic [3:0] c_off;
	logic [63:0] c_rdata;
	logic [15:0] tval;
	int fail_count = 0;
	int checked = 0;
	ocg_byte_t ta [9] = '{8'h84, 8'h86, 8'h87, 8'h88, 8'h8B, 8'h8E, 8'h85, 8'h8C, 8'h8D};
	ocg_byte_t td [9] = '{8'hFF, 8'h34, 8'h12, 8'h0F, 8'h55, 8'hFE, 8'hFF, 8'h00, 8'hFF};
	ocg_byte_t te [9] = '{8'h0F, 8'h34, 8'h12, 8'h0F, 8'h55, 8'h00, 8'h00, REV_VAL, ID_VAL};

	always #10 clk_in = ~clk_in;

	ocg_host_model host_u (.clk_in(clk_in), .bus_addr_out(addr), .bus_wdata_out(wdata),
		.bus_cs_n_out(cs_n), .bus_rd_n_out(rd_n), .bus_wr_n_out(wr_n),
		.bus_rdata_in(rdata), .bus_rdata_oe_n_in(oe_n));

	ocg_global_regs #(.REVISION(REV_VAL), .IDENTITY(ID_VAL), .NUM_CH(8)) dut_u (
		.clk_in(clk_in), .rst_in(rst_in), .bus_addr_in(addr), .bus_wdata_in(wdata),
		.bus_cs_n_in(cs_n), .bus_rd_n_in(rd_n), .bus_wr_n_in(wr_n),
		.bus_rdata_out(rdata), .bus_rdata_oe_n_out(oe_n), .chan_src_code_in(src),
		.chan_irq_enabled_in(irq_en), .chan_rdata_in(c_rdata), .timer_timeout_in(timeout),
		.device_asleep_in(asleep), .chan_offset_out(c_off), .chan_wdata_out(c_wd),
		.chan_wr_out(c_wr), .chan_rd_out(c_rd), .chan_soft_reset_out(c_rst),
		.octo_mode_out(octo), .quad_mode_out(quad), .sleep_enable_out(sleep),
		.timer_control_out(tctrl), .timer_value_out(tval));

	////////////////////////////////////////
	// remember the latest channel strobes
	always @(posedge clk_in) begin
		if (c_wr !== 8'h00) begin
			last_wr <= c_wr;
			last_off <= c_off;
			last_wd <= c_wd;
		end
		if (c_rd !== 8'h00) begin
			last_rd <= c_rd;
		end
		if (c_rst !== 8'h00) begin
			last_rst <= c_rst;
		end
	end

	task automatic chk(input ocg_byte_t got, input ocg_byte_t exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic rd(input ocg_byte_t a, input ocg_byte_t exp);
		ocg_byte_t d;
		logic on, off;
		host_u.access(a, 8'h00, 1'b1, d, on, off);
		chk(d, exp, "read data");
		chk({7'h00, on}, 8'h00, "drive during read");
		chk({7'h00, off}, 8'h01, "release after read");
	endtask : rd

	task automatic wr(input ocg_byte_t a, input ocg_byte_t d);
		ocg_byte_t u;
		logic x, y;
		host_u.access(a, d, 1'b0, u, x, y);
	endtask : wr

	task automatic pulse(input logic is_wake);
		@(posedge clk_in);
		if (is_wake) asleep <= 1'b1; else timeout <= 1'b1;
		repeat (3) @(posedge clk_in);
		asleep <= 1'b0;
		timeout <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask : pulse

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		give_verdict();
	end

	////////////////////////////////////////
	initial begin
		{src, irq_en, c_rdata, timeout, asleep} = '0;
		{last_wr, last_rd, last_rst, last_wd, last_off} = '0;
		for (int n = 0; n < 8; n++) c_rdata[8*n +: 8] = {n[3:0], 4'h9};
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		for (int a = 8'h80; a < 8'h84; a++) rd(a[7:0], 8'h00);
		rd(8'h8A, 8'h00);
		$display("test reset values done");
		exp_src = '0;
		for (int n = 1; n < 6; n++) exp_src[3*n +: 3] = n[2:0];
		@(posedge clk_in);
		for (int n = 0; n < 8; n++) src[3*n +: 3] <= n[2:0];
		irq_en <= 8'hBF;
		repeat (3) @(posedge clk_in);
		rd(8'h80, 8'h3E);
		rd(8'h81, exp_src[7:0]);
		rd(8'h82, exp_src[15:8]);
		rd(8'h83, exp_src[23:16]);
		src <= '0;
		irq_en <= 8'hFF;
		rd(8'h80, 8'h3E);
		rd(8'h12, 8'h19);
		chk(last_rd, 8'h02, "channel read strobe");
		rd(8'h25, 8'h29);
		rd(8'h36, 8'h39);
		rd(8'h40, 8'h49);
		rd(8'h80, 8'h30);
		$display("test interrupt summary done");
		for (int i = 0; i < 9; i++) begin
			wr(ta[i], td[i]);
			rd(ta[i], te[i]);
		end
		chk({4'h0, tctrl}, 8'h0F, "timer control out");
		chk(tval[15:8], 8'h12, "timer high out");
		chk(tval[7:0], 8'h34, "timer low out");
		chk(octo, 8'h0F, "octo out");
		chk(sleep, 8'h55, "sleep out");
		wr(8'h89, 8'h3C);
		chk(quad, 8'h30, "quad out");
		wr(8'h8A, 8'h81);
		chk(last_rst, 8'h81, "soft reset pulse");
		$display("test global registers done");
		wr(8'h13, 8'hAA);
		chk(last_wr, 8'h02, "single write strobe");
		chk({4'h0, last_off}, 8'h03, "write offset");
		chk(last_wd, 8'hAA, "write data");
		wr(8'h8E, 8'h01);
		rd(8'h8E, 8'h01);
		wr(8'h5F, 8'hC3);
		chk(last_wr, 8'hFF, "broadcast strobe");
		chk({4'h0, last_off}, 8'h0F, "broadcast offset");
		chk(last_wd, 8'hC3, "broadcast data");
		rd(8'h74, 8'h79);
		chk(last_rd, 8'h80, "broadcast read strobe");
		wr(8'h8E, 8'h00);
		$display("test channel access done");
		wr(8'h84, 8'h00);
		pulse(1'b0);
		rd(8'h81, 8'h00);
		rd(8'h85, 8'h01);
		rd(8'h85, 8'h00);
		wr(8'h84, 8'h01);
		pulse(1'b0);
		rd(8'h81, 8'h07);
		rd(8'h85, 8'h01);
		rd(8'h81, 8'h00);
		wr(8'h84, 8'h00);
		rd(8'h02, 8'h09);
		$display("test timer done");
		wr(8'h8B, 8'h7F);
		pulse(1'b1);
		rd(8'h80, 8'h30);
		wr(8'h8B, 8'hFF);
		pulse(1'b1);
		rd(8'h80, 8'h31);
		rd(8'h02, 8'h09);
		rd(8'h80, 8'h30);
		$display("test wake done");
		give_verdict();
	end
endmodule : ocg_global_regs_bench
